// file: logic/fp_range_pkg.sv
// Constants for the SIMD floating-point range exception block
package fp_range_pkg;
  // ****************************************************************
  // Register map (APB byte addresses)
  // ****************************************************************
  localparam logic [7:0] CTRL_ADDR     = 8'h00;
  localparam logic [7:0] STATUS_ADDR   = 8'h04;
  localparam logic [7:0] IRQ_ADDR      = 8'h08;
  localparam logic [7:0] MASK_ADDR     = 8'h0C;
  // ****************************************************************
  // Control fields: exception masks and rounding mode
  // ****************************************************************
  localparam int CTRL_PM_BIT = 0;
  localparam int CTRL_UM_BIT = 1;
  localparam int CTRL_OM_BIT = 2;
  localparam int CTRL_RC_LSB = 3;
  localparam logic [4:0] CTRL_RESET = 5'h07;
  // Rounding modes
  localparam logic [1:0] RND_NEAR = 2'h0;
  localparam logic [1:0] RND_DOWN = 2'h1;
  localparam logic [1:0] RND_UP   = 2'h2;
  localparam logic [1:0] RND_ZERO = 2'h3;
  // Flag bit positions in status and interrupt registers
  localparam int FLG_PE = 0;
  localparam int FLG_UE = 1;
  localparam int FLG_OE = 2;
  // ****************************************************************
  // Formats: exponent width, bias and trap scaling
  // ****************************************************************
  localparam int S_EXP_W  = 8;
  localparam int S_MAN_W  = 23;
  localparam int D_EXP_W  = 11;
  localparam int D_MAN_W  = 52;
  localparam int S_BIAS   = 127;
  localparam int D_BIAS   = 1023;
  localparam int S_EMAX   = 127;
  localparam int D_EMAX   = 1023;
  localparam int S_SCALE  = 192;
  localparam int D_SCALE  = 1536;
  localparam int UEXP_W   = 14;
endpackage : fp_range_pkg

// file: logic/fp_range_exc.sv
// SIMD floating-point overflow, underflow and inexact response unit
//
// Behaviour
// (RQ1) Overflow when rounded result exceeds the largest finite normal value.
// (RQ2) Masked overflow, round-nearest: signed infinity, overflow and precision.
// (RQ3) Single, round-down: +max finite (exp 127) or -infinity, both flags.
// (RQ4) Single, round-up: +infinity or -max finite (exp 127), both flags.
// (RQ5) Single, round-zero: signed max finite magnitude, both flags.
// (RQ6) Double uses the same selection with max finite at exponent 1023.
// (RQ7) Unmasked overflow: unbounded result scaled down by 2^192 or 2^1536.
// (RQ8) Unmasked overflow/underflow: precision flag only when inexact.
// (RQ9) Underflow when unbounded rounded result is below smallest normal.
// (RQ10) Masked underflow: zero/denormal/normal, flags only when inexact.
// (RQ11) Unmasked underflow: unbounded result scaled up by 2^192 or 2^1536.
// (RQ12) Range checks cover arithmetic ops and double-to-single narrowing.
// (RQ13) Inexact flagged whenever the value is not exactly representable.
// (RQ14) Masked inexact: bounded rounded result with precision flag.
// (RQ15) Inexact may accompany masked overflow or underflow.
// (RQ16) Unmasked inexact keeps masked range responses and sets precision.
// (RQ17) Rounding mode comes from the control and status register.
// (RQ18) Unmasked condition raises an exception request with biased result.
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module fp_range_exc
  import fp_range_pkg::*;
(
  // Clock and reset
  input  wire  logic        pclk,
  input  wire  logic        presetn,
  // APB slave
  input  wire  logic        psel,
  input  wire  logic        penable,
  input  wire  logic        pwrite,
  input  wire  logic [7:0]  paddr,
  input  wire  logic [31:0] pwdata,
  output var   logic [31:0] prdata,
  output var   logic        pready,
  output var   logic        pslverr,
  // Datapath result: sign, unbounded exponent (unbiased), fraction
  input  wire  logic        res_valid,
  input  wire  logic        res_double,
  input  wire  logic        res_range_op,
  input  wire  logic        res_sign,
  input  wire  logic signed [UEXP_W-1:0] res_uexp,
  input  wire  logic [D_MAN_W-1:0] res_frac,
  input  wire  logic        res_inexact,
  input  wire  logic        res_is_zero,
  input  wire  logic [63:0] res_bounded,
  // Delivered result and trap request
  output var   logic        out_valid,
  output var   logic [63:0] out_result,
  output var   logic [2:0]  out_flags,
  output var   logic        trap_req,
  output var   logic        irq
);
  // Overview of the result path:
  // The datapath hands over one result per res_valid pulse, already
  // rounded to the destination precision but with an exponent that
  // has not been clamped to the format. This unit decides whether
  // that value is too large or too small for the format, picks the
  // delivered word and raises the status flags.
  // Everything is decided combinationally in the cycle of res_valid
  // and registered once, so a new result may arrive every cycle.
  // The trap word keeps the fraction and only rebiases the exponent,
  // which lets the handler rescale without redoing the rounding.
  // Limitation: a zero result is never treated as out of range, and
  // the datapath must flag inexact itself; no sticky bits live here.
  // ****************************************************************
  // Range detection
  // ****************************************************************
  logic signed [UEXP_W-1:0] emax, emin, scale, sexp;
  wire  range_ok   = res_range_op & ~res_is_zero;                // RQ12
  assign emax  = res_double ? UEXP_W'(D_EMAX) : UEXP_W'(S_EMAX);
  assign emin  = res_double ? UEXP_W'(1 - D_BIAS) : UEXP_W'(1 - S_BIAS);
  assign scale = res_double ? UEXP_W'(D_SCALE) : UEXP_W'(S_SCALE);
  wire  ovf        = range_ok & (res_uexp > emax);               // RQ1
  wire  unf        = range_ok & (res_uexp < emin);               // RQ9
  wire  inx        = res_inexact;                                // RQ13
  logic [4:0] ctrl_reg;
  wire  [1:0] rmode = ctrl_reg[CTRL_RC_LSB +: 2];                 // RQ17
  wire  om = ctrl_reg[CTRL_OM_BIT];
  wire  um = ctrl_reg[CTRL_UM_BIT];
  wire  pm = ctrl_reg[CTRL_PM_BIT];
  // ****************************************************************
  // Masked overflow result: infinity or largest finite
  // ****************************************************************
  wire  to_inf = (rmode == RND_NEAR) |                            // RQ2
                 ((rmode == RND_DOWN) & res_sign) |               // RQ3
                 ((rmode == RND_UP) & ~res_sign);                 // RQ4 RQ5
  wire [63:0] s_inf = {32'h0, res_sign, 8'hFF, 23'h0};
  wire [63:0] s_max = {32'h0, res_sign, 8'hFE, 23'h7FFFFF};
  wire [63:0] d_inf = {res_sign, 11'h7FF, 52'h0};
  wire [63:0] d_max = {res_sign, 11'h7FE, 52'hFFFFFFFFFFFFF};    // RQ6
  wire [63:0] ovf_masked = res_double ? (to_inf ? d_inf : d_max)
                                      : (to_inf ? s_inf : s_max);
  // ****************************************************************
  // Unmasked result: exponent rebias by the trap scale
  // ****************************************************************
  assign sexp = ovf ? res_uexp - scale : res_uexp + scale;       // RQ7 RQ11
  wire [UEXP_W-1:0] sb_s = UEXP_W'(sexp + UEXP_W'(S_BIAS));
  wire [UEXP_W-1:0] sb_d = UEXP_W'(sexp + UEXP_W'(D_BIAS));
  wire [63:0] scaled = res_double ?
    {res_sign, sb_d[D_EXP_W-1:0], res_frac} :
    {32'h0, res_sign, sb_s[S_EXP_W-1:0], res_frac[D_MAN_W-1 -: S_MAN_W]};
  // ****************************************************************
  // Response selection and flags
  // ****************************************************************
  wire  ovf_trap = ovf & ~om;
  wire  unf_trap = unf & ~um;
  wire  range_trap = ovf_trap | unf_trap;
  // Masked underflow flags only when inexact; unmasked always
  wire  unf_flag = unf & (unf_trap | inx);                       // RQ10
  wire  pe_flag  = ovf ? (ovf_trap ? inx : 1'b1) : inx;          // RQ8 RQ15
  wire [63:0] result_sel = range_trap ? scaled :
                           ovf ? ovf_masked : res_bounded;       // RQ14 RQ16
  wire [2:0] flags_sel = {ovf, unf_flag, pe_flag};
  wire  trap_sel = range_trap | (pe_flag & ~pm);                 // RQ18
  // Result pipeline stage, one cycle after res_valid
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_valid  <= 1'b0;
      out_result <= 64'h0;
      out_flags  <= 3'h0;
      trap_req   <= 1'b0;
    end else begin
      out_valid  <= res_valid;
      out_result <= res_valid ? result_sel : out_result;
      out_flags  <= res_valid ? flags_sel : 3'h0;
      trap_req   <= res_valid & trap_sel;                        // RQ18
    end
  end
  // ****************************************************************
  // APB registers: control, sticky status, interrupt mask
  // ****************************************************************
  wire  wr   = psel & penable & pwrite;
  wire  rd   = psel & penable & ~pwrite;
  wire  hit_ctrl = (paddr == CTRL_ADDR);
  wire  hit_stat = (paddr == STATUS_ADDR);
  wire  hit_irq  = (paddr == IRQ_ADDR);
  wire  hit_mask = (paddr == MASK_ADDR);
  wire  mapped = hit_ctrl | hit_stat | hit_irq | hit_mask;
  logic [2:0] status_reg, istat_reg, imask_reg;
  wire  [2:0] new_flags = res_valid ? flags_sel : 3'h0;
  // Read-to-clear; a flag set in the same cycle survives
  wire  [2:0] status_next = (rd & hit_stat ? 3'h0 : status_reg) | new_flags;
  wire  [2:0] istat_next  = (rd & hit_irq ? 3'h0 : istat_reg) | new_flags;
  logic [31:0] rdata_next;
  always_comb begin
    rdata_next = 32'h0;
    if (hit_ctrl) begin
      rdata_next = {27'h0, ctrl_reg};
    end else if (hit_stat) begin
      rdata_next = {29'h0, status_reg};
    end else if (hit_irq) begin
      rdata_next = {29'h0, istat_reg};
    end else if (hit_mask) begin
      rdata_next = {29'h0, imask_reg};
    end
  end
  // Zero wait states: pready is registered high in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg   <= CTRL_RESET;
      status_reg <= 3'h0;
      istat_reg  <= 3'h0;
      imask_reg  <= 3'h0;
      prdata     <= 32'h0;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      irq        <= 1'b0;
    end else begin
      ctrl_reg   <= (wr & hit_ctrl) ? pwdata[4:0] : ctrl_reg;
      imask_reg  <= (wr & hit_mask) ? pwdata[2:0] : imask_reg;
      status_reg <= status_next;
      istat_reg  <= istat_next;
      prdata     <= (psel & ~penable & ~pwrite) ? rdata_next : prdata;
      pready     <= psel & ~penable;
      pslverr    <= psel & ~penable & ~mapped;
      irq        <= |(istat_next & imask_reg);
    end
  end
  // ****************************************************************
  // Checks
  // ****************************************************************
  a_ovf_round_near: assert property (@(posedge pclk) disable iff (!presetn)
    res_valid & ovf & om & (rmode == RND_NEAR) & ~res_double
    |=> out_result[30:0] == 31'h7F800000 && out_flags[FLG_OE]
        && out_flags[FLG_PE]) else $error("masked overflow not infinity"); // RQ2
  a_ovf_round_zero: assert property (@(posedge pclk) disable iff (!presetn)
    res_valid & ovf & om & (rmode == RND_ZERO) & ~res_double
    |=> out_result[30:0] == 31'h7F7FFFFF) else $error("bad round-zero max"); // RQ5
  a_ovf_dbl_max: assert property (@(posedge pclk) disable iff (!presetn)
    res_valid & ovf & om & (rmode == RND_ZERO) & res_double
    |=> out_result[62:0] == 63'h7FEFFFFFFFFFFFFF) else $error("bad dbl max"); // RQ6
  a_unf_masked_exact: assert property (@(posedge pclk) disable iff (!presetn)
    res_valid & unf & um & ~inx |=> out_flags == 3'h0)
    else $error("exact masked underflow flagged"); // RQ10
  a_trap_on_unmask: assert property (@(posedge pclk) disable iff (!presetn)
    res_valid & (ovf_trap | unf_trap) |=> trap_req && out_valid)
    else $error("missing trap request"); // RQ18
  a_trap_sign_kept: assert property (@(posedge pclk) disable iff (!presetn)
    res_valid & range_trap & res_double |=> out_result[63] == $past(res_sign))
    else $error("trap result sign lost"); // RQ7
  a_pe_unmasked: assert property (@(posedge pclk) disable iff (!presetn)
    res_valid & range_trap & ~inx |=> !out_flags[FLG_PE])
    else $error("precision set on exact trap"); // RQ8
  a_inexact_flag: assert property (@(posedge pclk) disable iff (!presetn)
    res_valid & inx & ~ovf & ~unf |=> out_flags[FLG_PE]
      && out_result == $past(res_bounded)) else $error("inexact lost"); // RQ14
  // ****************************************************************
  // Masked overflow responses for each rounding mode, both signs only in single round-down and round-up and in double round-near
  // ****************************************************************
  a_dn_pos: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
    res_valid & ovf & om & (rmode == RND_DOWN) & ~res_double & ~res_sign
    |=> out_result[31:0] == 32'h7F7FFFFF)
    else $error("round-down positive not max");

  a_dn_neg: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
    res_valid & ovf & om & (rmode == RND_DOWN) & ~res_double & res_sign
    |=> out_result[31:0] == 32'hFF800000)
    else $error("round-down negative not infinity");

  a_up_pos: assert property (@(posedge pclk) disable iff (!presetn) // RQ4
    res_valid & ovf & om & (rmode == RND_UP) & ~res_double & ~res_sign
    |=> out_result[31:0] == 32'h7F800000)
    else $error("round-up positive not infinity");

  a_up_neg: assert property (@(posedge pclk) disable iff (!presetn) // RQ4
    res_valid & ovf & om & (rmode == RND_UP) & ~res_double & res_sign
    |=> out_result[31:0] == 32'hFF7FFFFF)
    else $error("round-up negative not max");

  a_zero_neg: assert property (@(posedge pclk) disable iff (!presetn) // RQ5
    res_valid & ovf & om & (rmode == RND_ZERO) & ~res_double & res_sign
    |=> out_result[31:0] == 32'hFF7FFFFF)
    else $error("round-zero negative not max");

  a_near_neg: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
    res_valid & ovf & om & (rmode == RND_NEAR) & ~res_double & res_sign
    |=> out_result[31:0] == 32'hFF800000)
    else $error("round-near negative not infinity");

  a_dbl_inf: assert property (@(posedge pclk) disable iff (!presetn) // RQ6
    res_valid & ovf & om & (rmode == RND_NEAR) & res_double
    |=> out_result[62:0] == 63'h7FF0000000000000)
    else $error("double round-near not infinity");

  a_dbl_down: assert property (@(posedge pclk) disable iff (!presetn) // RQ6
    res_valid & ovf & om & (rmode == RND_DOWN) & res_double & ~res_sign
    |=> out_result == 64'h7FEFFFFFFFFFFFFF)
    else $error("double round-down not max");

  a_dbl_up: assert property (@(posedge pclk) disable iff (!presetn) // RQ6
    res_valid & ovf & om & (rmode == RND_UP) & res_double & res_sign
    |=> out_result == 64'hFFEFFFFFFFFFFFFF)
    else $error("double round-up not max");

  a_ovf_flags: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
    res_valid & ovf & om
    |=> out_flags[FLG_OE] && out_flags[FLG_PE])
    else $error("masked overflow flags missing");

  // ****************************************************************
  // Range detection against the format limits
  // ****************************************************************
  a_ovf_detect: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
    res_valid & res_range_op & ~res_is_zero & (res_uexp > emax)
    |=> out_flags[FLG_OE])
    else $error("overflow not flagged");

  a_no_ovf: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
    res_valid & (res_uexp <= emax)
    |=> !out_flags[FLG_OE])
    else $error("overflow flagged in range");

  a_unf_det: assert property (@(posedge pclk) disable iff (!presetn) // RQ9
    res_valid & res_range_op & ~res_is_zero & (res_uexp < emin) & ~um
    |=> out_flags[FLG_UE])
    else $error("underflow not flagged");

  a_no_unf: assert property (@(posedge pclk) disable iff (!presetn) // RQ9
    res_valid & (res_uexp >= emin)
    |=> !out_flags[FLG_UE])
    else $error("underflow flagged in range");

  // ****************************************************************
  // Trap results: sign and fraction kept, exponent rebiased
  // ****************************************************************
  a_sgl_sign: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
    res_valid & ovf_trap & ~res_double
    |=> out_result[31] == $past(res_sign))
    else $error("single trap sign lost");

  a_dbl_frac: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
    res_valid & ovf_trap & res_double
    |=> out_result[51:0] == $past(res_frac))
    else $error("overflow trap fraction lost");

  a_unf_frac: assert property (@(posedge pclk) disable iff (!presetn) // RQ11
    res_valid & unf_trap & res_double
    |=> out_result[51:0] == $past(res_frac))
    else $error("underflow trap fraction lost");

  a_unf_trap: assert property (@(posedge pclk) disable iff (!presetn) // RQ11
    res_valid & unf_trap
    |=> out_flags[FLG_UE] && trap_req)
    else $error("unmasked underflow not raised");

  a_ovf_oe: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
    res_valid & ovf_trap
    |=> out_flags[FLG_OE] && trap_req)
    else $error("unmasked overflow not raised");

  // ****************************************************************
  // Masked underflow and precision
  // ****************************************************************
  a_unf_inx: assert property (@(posedge pclk) disable iff (!presetn) // RQ10
    res_valid & unf & um & inx
    |=> out_flags[FLG_UE] && out_flags[FLG_PE])
    else $error("inexact masked underflow unflagged");

  a_unf_res: assert property (@(posedge pclk) disable iff (!presetn) // RQ10
    res_valid & unf & um
    |=> out_result == $past(res_bounded))
    else $error("masked underflow result wrong");

  a_no_range: assert property (@(posedge pclk) disable iff (!presetn) // RQ12
    res_valid & ~res_range_op
    |=> out_flags[FLG_OE:FLG_UE] == 2'h0)
    else $error("range flag on unchecked op");

  a_inx_any: assert property (@(posedge pclk) disable iff (!presetn) // RQ13
    res_valid & inx
    |=> out_flags[FLG_PE])
    else $error("inexact not flagged");

  a_exact_pe: assert property (@(posedge pclk) disable iff (!presetn) // RQ13
    res_valid & ~inx & ~(ovf & om)
    |=> !out_flags[FLG_PE])
    else $error("precision set on exact result");

  // ****************************************************************
  // Trap request, control and output timing
  // ****************************************************************
  a_pe_trap: assert property (@(posedge pclk) disable iff (!presetn) // RQ18
    res_valid & inx & ~pm
    |=> trap_req)
    else $error("unmasked inexact not raised");

  a_no_trap: assert property (@(posedge pclk) disable iff (!presetn) // RQ18
    res_valid & ~ovf & ~unf & ~inx
    |=> !trap_req)
    else $error("spurious trap request");

  a_unmask_pe: assert property (@(posedge pclk) disable iff (!presetn) // RQ16
    res_valid & ovf & om & ~pm
    |=> out_flags[FLG_OE] && out_result == $past(ovf_masked))
    else $error("masked overflow lost with precision trap");

  a_rnd_ctrl: assert property (@(posedge pclk) disable iff (!presetn) // RQ17
    psel & penable & pwrite & (paddr == CTRL_ADDR)
    |=> rmode == $past(pwdata[CTRL_RC_LSB +: 2]))
    else $error("rounding mode not taken");

  a_inx_ovf: assert property (@(posedge pclk) disable iff (!presetn) // RQ15
    res_valid & ovf & om & inx
    |=> out_flags == 3'h5)
    else $error("inexact masked overflow flags");

  a_out_lat: assert property (@(posedge pclk) disable iff (!presetn) // RQ12
    res_valid
    |=> out_valid)
    else $error("result not delivered");

  a_idle_out: assert property (@(posedge pclk) disable iff (!presetn) // RQ18
    !res_valid
    |=> !out_valid && out_flags == 3'h0 && !trap_req)
    else $error("output without result");
endmodule : fp_range_exc
`default_nettype wire

// file: tb/fp_datapath_model.sv
// Datapath model that hands rounded results to the range unit
`timescale 1ns/10ps
`default_nettype none
module fp_datapath_model
  import fp_range_pkg::*;
#(
  parameter logic [51:0] FRAC = 52'h0,
  parameter logic [63:0] BND  = 64'h0
)(
  // Clock
  input  wire logic                    pclk,
  // Result lane
  output var  logic                    res_valid,
  output var  logic                    res_double,
  output var  logic                    res_range_op,
  output var  logic                    res_sign,
  output var  logic signed [UEXP_W-1:0] res_uexp,
  output var  logic [D_MAN_W-1:0]      res_frac,
  output var  logic                    res_inexact,
  output var  logic                    res_is_zero,
  output var  logic [63:0]             res_bounded
);
  // Idle lane at time zero
  initial begin
    {res_valid, res_double, res_range_op, res_sign} = 4'h0;
    {res_inexact, res_is_zero, res_uexp} = '0;
    res_frac = ~FRAC;
    res_bounded = ~BND;
  end
  // One-cycle result pulse; afterwards inverted exponent, fraction and bounded word, never a stale copy of those
  task automatic send(input logic d, op, s,
                      input logic signed [UEXP_W-1:0] ue, input logic inx);
    @(posedge pclk);
    {res_valid, res_double, res_range_op, res_sign} <= {1'b1, d, op, s};
    res_inexact <= inx;
    res_uexp <= ue;
    res_frac <= FRAC;
    res_bounded <= BND;
    @(posedge pclk);
    res_valid <= 1'b0;
    res_uexp <= ~ue;
    res_frac <= ~FRAC;
    res_bounded <= ~BND;
  endtask : send
endmodule : fp_datapath_model
`default_nettype wire

// file: tb/test_fp_range_exc.sv
// Self-checking bench for the range exception unit
`timescale 1ns/10ps
`default_nettype none
module test_fp_range_exc import fp_range_pkg::*;;
  localparam logic [51:0] FRAC = 52'hA5A5A5A5A5A5A;
  localparam logic [63:0] BND  = 64'h0123456789ABCDEF;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, inf, res_valid, res_double, res_range_op;
  logic res_sign, res_inexact, res_is_zero, out_valid, trap_req, irq;
  logic signed [UEXP_W-1:0] res_uexp;
  logic [D_MAN_W-1:0] res_frac;
  logic [63:0] res_bounded, out_result, ex;
  logic [2:0] out_flags;
  int failures = 0, checked = 0;
  // Clock at 100 MHz
  always #5 pclk = ~pclk;
  fp_range_exc dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .res_valid(res_valid), .res_double(res_double),
    .res_range_op(res_range_op), .res_sign(res_sign), .res_uexp(res_uexp),
    .res_frac(res_frac), .res_inexact(res_inexact),
    .res_is_zero(res_is_zero), .res_bounded(res_bounded),
    .out_valid(out_valid), .out_result(out_result), .out_flags(out_flags),
    .trap_req(trap_req), .irq(irq));
  fp_datapath_model #(.FRAC(FRAC), .BND(BND)) m_u (.pclk(pclk),
    .res_valid(res_valid), .res_double(res_double),
    .res_range_op(res_range_op), .res_sign(res_sign), .res_uexp(res_uexp),
    .res_frac(res_frac), .res_inexact(res_inexact),
    .res_is_zero(res_is_zero), .res_bounded(res_bounded));
  // ****************************************
  // Report, compare and APB master
  // ****************************************
  task end_of_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test
  task chk(input string nm, input logic [63:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Request held until pready is seen; bounded wait guards a hang
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    // Sample pready at the rising edge; data taken at that same edge
    for (i = 0; i < 8; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 8) begin
      failures++;
      end_of_test;
    end
    {rd, err} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask : apb
  // One result; single format compared in the low word only
  task res(input logic d, op, s, input int ue, input logic inx,
           input logic [63:0] e, input logic [2:0] f, input logic t);
    m_u.send(d, op, s, ue[UEXP_W-1:0], inx);
    #1;
    chk("out_valid", out_valid, 1'b1);
    chk("out_result", d ? out_result : {32'h0, out_result[31:0]}, e);
    chk("out_flags", out_flags, f);
    chk("trap_req", trap_req, t);
  endtask : res
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk("idle", {out_valid, trap_req, irq, pready}, 4'h0);
    apb(0, CTRL_ADDR, 0);
    chk("ctrl", rd[4:0], CTRL_RESET);
    apb(1, MASK_ADDR, 32'h7);
    // Masked overflow: every format, rounding mode and sign
    for (int d = 0; d < 2; d++) for (int m = 0; m < 4; m++)
      for (int s = 0; s < 2; s++) begin
        apb(1, CTRL_ADDR, {27'h0, m[1:0], 3'h7});
        inf = m == RND_NEAR || (m == RND_DOWN && s) || (m == RND_UP && !s);
        ex = d ? {s[0], inf ? 63'h7FF0000000000000 : 63'h7FEFFFFFFFFFFFFF}
               : {32'h0, s[0], inf ? 31'h7F800000 : 31'h7F7FFFFF};
        res(d[0], 1, s[0], d ? 1024 : 128, 1, ex, 3'h5, 0);
      end
    // Sticky status, read clear, interrupt raise, mask and clear
    repeat (2) @(posedge pclk);
    #1 chk("irq", irq, 1'b1);
    apb(1, MASK_ADDR, 32'h0);
    repeat (2) @(posedge pclk);
    #1 chk("irq", irq, 1'b0);
    apb(1, MASK_ADDR, 32'h7);
    apb(0, STATUS_ADDR, 0);
    chk("status", rd[2:0], 3'h5);
    apb(0, STATUS_ADDR, 0);
    chk("status", rd[2:0], 3'h0);
    apb(0, IRQ_ADDR, 0);
    repeat (2) @(posedge pclk);
    #1 chk("irq", {rd[2:0], irq}, 4'hA);
    // Unmasked overflow and underflow hand over rebiased results
    apb(1, CTRL_ADDR, 32'h3);
    res(0, 1, 0, 128, 0, {33'h0, 8'h3F, FRAC[51:29]}, 3'h4, 1);
    res(1, 1, 1, 1024, 1, {1'b1, 11'h1FF, FRAC}, 3'h5, 1);
    apb(1, CTRL_ADDR, 32'h5);
    res(0, 1, 1, -130, 1, {32'h1, 8'hBD, FRAC[51:29]}, 3'h3, 1);
    res(1, 1, 0, -1030, 0, {1'b0, 11'h5F9, FRAC}, 3'h2, 1);
    // Masked underflow exact and inexact, then a non-range inexact op
    apb(1, CTRL_ADDR, 32'h7);
    res(0, 1, 0, -130, 0, {32'h0, BND[31:0]}, 3'h0, 0);
    res(1, 1, 0, -1030, 1, BND, 3'h3, 0);
    res(0, 0, 0, 200, 1, {32'h0, BND[31:0]}, 3'h1, 0);
    // Precision unmasked: overflow response stays the masked one
    apb(1, CTRL_ADDR, 32'h6);
    res(1, 1, 1, 5, 1, BND, 3'h1, 1);
    res(0, 1, 0, 128, 0, {32'h0, 32'h7F800000}, 3'h5, 1);
    // Unmapped address is refused
    apb(1, 8'h10, 32'hFFFFFFFF);
    chk("pslverr", err, 1'b1);
    apb(0, 8'h10, 0);
    chk("unmapped", {err, rd}, {1'b1, 32'h0});
    end_of_test;
  end
endmodule : test_fp_range_exc
`default_nettype wire
